// file: hw/nsw_cfg.svh
// Constants of the nonvolatile self-write controller: offsets, bit
// positions, reset values, keys and timing.
// Assumes a 50 MHz core clock and a 32-bit AHB-Lite register bus.
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// (R1) Power-on reset clears commit_permit, blocking every write until software sets it.
// (R2) Data writes are refused while the 64 ms power-up interval runs.
// (R3) A write starts only with commit_permit set and unlock completed.
// (R4) Unlock is 55h then 0AAh to the unlock port, then commit_strobe.
// (R5) Software idles one instruction after a flash-word commit.
// (R6) Software starts a flash block at an index ending in 000.
// (R7) A flash word is nvm_byte_high over nvm_byte_low, loaded before commit.
// (R8) Software masks interrupts around the unlock and commit writes.
// (R9) Data memory holds one byte per index value.
// (R10) Software verifies data writes by reading back and comparing.
// (R11) data_protect_fuse at 0 marks data memory as protected.
// (R12) Protected data memory is reachable by the processor only, not externally.
// (R13) commit_strobe cannot be set unless commit_permit is already set.
// (R14) Finished data write clears commit_strobe and sets nvm_done_flag.
// (R15) Commit at index low bits 111 erases sixteen words, writes eight buffered.
// (R16) Code fetch reads in the second cycle, shows data the next cycle.
// (R17) Unlock keys must be consecutive accesses; anything else drops the tracker.
// (R18) A warm reset during a write sets commit_abort_flag, which survives it.
`ifndef NSW_CFG_SVH
`define NSW_CFG_SVH
// Register offsets (byte addresses)
`define NSW_OFF_CONTROL 8'h00
`define NSW_OFF_UNLOCK 8'h04
`define NSW_OFF_IDX_LO 8'h08
`define NSW_OFF_IDX_HI 8'h0C
`define NSW_OFF_BYTE_LO 8'h10
`define NSW_OFF_BYTE_HI 8'h14
`define NSW_OFF_IRQ_STAT 8'h18
`define NSW_OFF_IRQ_MASK 8'h1C
// Control bit positions
`define NSW_B_FETCH 0
`define NSW_B_STROBE 1
`define NSW_B_PERMIT 2
`define NSW_B_ABORT 3
`define NSW_B_CODE 7
// Interrupt status and mask bit
`define NSW_B_DONE 0
// Field widths
`define NSW_IDX_HI_W 5
`define NSW_BYTE_HI_W 6
`define NSW_WORD_W 14
`define NSW_PF_AW 13
// Unlock keys
`define NSW_KEY_FIRST 8'h55
`define NSW_KEY_SECOND 8'hAA
// Flash block shape and erased value
`define NSW_BLK_LAST 3'h7
`define NSW_ERASED 14'h3FFF
// Timing
`define NSW_CLK_KHZ 50000
`define NSW_PWRT_MS 64
`define NSW_PWRT_CYC (`NSW_PWRT_MS * `NSW_CLK_KHZ)
`define NSW_WR_CYC 16
`define NSW_FETCH_LAT 2'h2
`endif

// file: hw/nsw_pkg.sv
// Types shared by the self-write controller files.
// Assumes nsw_cfg.svh is compiled alongside.
package nsw_pkg;
  // Unlock tracker states
  typedef enum logic [1:0] {
    NSW_UL_IDLE = 2'b00,
    NSW_UL_GOT_FIRST = 2'b01,
    NSW_UL_ARMED = 2'b10
  } nsw_unlock_e;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
  } nsw_aphase_s;

  // Pending write operation
  typedef struct packed {
    logic is_code;
    logic [12:0] index;
    logic [7:0] data;
  } nsw_op_s;
endpackage : nsw_pkg

// file: hw/nsw_unlock.sv
// Unlock-key tracker for the self-write controller.
// Assumes one event per completed bus transfer, synchronous to clock.
`include "nsw_cfg.svh"
module nsw_unlock (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clear,
  // Transfer events
  input wire logic key_wr,
  input wire logic [7:0] key_val,
  input wire logic other_acc,
  // Result
  output logic armed
);
  nsw_pkg::nsw_unlock_e state, next_state;

  // Keys must arrive back to back; any stray access restarts
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state = nsw_pkg::NSW_UL_IDLE;
    end else if (key_wr) begin
      case (state)
        nsw_pkg::NSW_UL_IDLE: begin
          next_state = (key_val == `NSW_KEY_FIRST) ? nsw_pkg::NSW_UL_GOT_FIRST
                                                   : nsw_pkg::NSW_UL_IDLE; // [R4] [R17]
        end
        nsw_pkg::NSW_UL_GOT_FIRST: begin
          next_state = (key_val == `NSW_KEY_SECOND) ? nsw_pkg::NSW_UL_ARMED
                                                    : nsw_pkg::NSW_UL_IDLE; // [R4] [R17]
        end
        default: begin
          next_state = nsw_pkg::NSW_UL_IDLE;
        end
      endcase
    end else if (other_acc) begin
      next_state = nsw_pkg::NSW_UL_IDLE; // [R17]
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= nsw_pkg::NSW_UL_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign armed = (state == nsw_pkg::NSW_UL_ARMED);
endmodule : nsw_unlock

// file: hw/nsw_top.sv
// Nonvolatile self-write controller: data EEPROM and program flash
// behind an AHB-Lite register slave.
// Assumes resetn is the power-on reset and warm_reset a synchronous
// reset of any other cause; all inputs synchronous to clock.
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`include "nsw_cfg.svh"
module nsw_top #(
  parameter int PWRT_CYC = `NSW_PWRT_CYC,
  parameter int WR_CYC = `NSW_WR_CYC
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic warm_reset,
  // Configuration fuse
  input wire logic data_protect_fuse,
  // External programming read port
  input wire logic ext_rd,
  input wire logic [7:0] ext_addr,
  output logic [7:0] ext_rdata,
  output logic ext_denied,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Status
  output logic irq,
  output logic busy
);
  localparam int PW = $clog2(PWRT_CYC + 1);
  localparam int WW = $clog2(WR_CYC + 1);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  nsw_pkg::nsw_aphase_s ap, next_ap;
  nsw_pkg::nsw_op_s op, next_op;
  logic code_sel, next_code_sel;
  logic abort_flag, next_abort_flag;
  logic permit, next_permit;
  logic strobe, next_strobe;
  logic fetch, next_fetch;
  logic [7:0] idx_lo, next_idx_lo;
  logic [`NSW_IDX_HI_W-1:0] idx_hi, next_idx_hi;
  logic [7:0] byte_lo, next_byte_lo;
  logic [`NSW_BYTE_HI_W-1:0] byte_hi, next_byte_hi;
  logic done_flag, next_done_flag;
  logic done_mask, next_done_mask;
  logic [PW-1:0] pwrt, next_pwrt;
  logic [WW-1:0] wcnt, next_wcnt;
  logic [1:0] fstage, next_fstage;
  logic [31:0] rdata, next_rdata;
  logic [7:0] ext_q, next_ext_q;
  logic ext_den_q, next_ext_den_q;
  logic [`NSW_WORD_W-1:0] blkbuf [8];
  logic [`NSW_WORD_W-1:0] next_blkbuf [8];
  logic [7:0] ee_mem [256];
  logic [`NSW_WORD_W-1:0] pf_mem [1 << `NSW_PF_AW];

  logic armed, take, dwr, drd, key_wr, commit_ok, finish;
  logic [`NSW_PF_AW-1:0] index;
  logic [7:0] wb;

  assign take = hsel & hready & htrans[1];
  assign dwr = ap.valid & ap.write;
  assign drd = ap.valid & ~ap.write;
  assign key_wr = dwr & (ap.offset == `NSW_OFF_UNLOCK);
  assign wb = hwdata[7:0];
  assign index = {idx_hi, idx_lo};
  assign finish = strobe & (wcnt == WW'(1));

  //------------------------------------------------------------
  // Unlock tracker
  //------------------------------------------------------------
  nsw_unlock u_unlock (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .clear(warm_reset),
    .key_wr(key_wr),
    .key_val(wb),
    .other_acc(ap.valid & ~key_wr),
    .armed(armed)
  );

  // Read decode, used only for the bus read data
  function automatic logic [31:0] rd_reg(input logic [7:0] off, input logic [7:0] ctl,
                                         input logic [7:0] lo, input logic [7:0] hi,
                                         input logic [7:0] bl, input logic [7:0] bh,
                                         input logic st, input logic mk);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (off)
      `NSW_OFF_CONTROL: r[7:0] = ctl;
      `NSW_OFF_IDX_LO: r[7:0] = lo;
      `NSW_OFF_IDX_HI: r[7:0] = hi;
      `NSW_OFF_BYTE_LO: r[7:0] = bl;
      `NSW_OFF_BYTE_HI: r[7:0] = bh;
      `NSW_OFF_IRQ_STAT: r[`NSW_B_DONE] = st;
      `NSW_OFF_IRQ_MASK: r[`NSW_B_DONE] = mk;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_reg

  //------------------------------------------------------------
  // Next-state logic
  //------------------------------------------------------------
  // Commit is judged on the permit bit held before this write
  assign commit_ok = permit & armed & ~strobe; // [R3] [R13]

  always_comb begin
    logic [7:0] ctl;
    ctl = 8'h00;
    ctl[`NSW_B_CODE] = code_sel;
    ctl[`NSW_B_ABORT] = abort_flag;
    ctl[`NSW_B_PERMIT] = permit;
    ctl[`NSW_B_STROBE] = strobe;
    ctl[`NSW_B_FETCH] = fetch;
    next_ap = '{valid: take, write: hwrite, offset: haddr[7:0]};
    next_op = op;
    next_code_sel = code_sel;
    next_abort_flag = abort_flag;
    next_permit = permit;
    next_strobe = strobe;
    next_fetch = fetch;
    next_idx_lo = idx_lo;
    next_idx_hi = idx_hi;
    next_byte_lo = byte_lo;
    next_byte_hi = byte_hi;
    next_done_flag = done_flag;
    next_done_mask = done_mask;
    next_pwrt = (pwrt != '0) ? pwrt - PW'(1) : pwrt;
    next_wcnt = (wcnt != '0) ? wcnt - WW'(1) : wcnt;
    next_fstage = fstage;
    next_rdata = rdata;
    next_blkbuf = blkbuf;
    // Protected data memory answers only the processor
    next_ext_den_q = ext_rd & ~data_protect_fuse; // [R11] [R12]
    next_ext_q = (ext_rd & data_protect_fuse) ? ee_mem[ext_addr] : 8'h00; // [R12]
    // Reads are answered one wait state after the address phase
    if (drd) begin
      next_rdata = rd_reg(ap.offset, ctl, idx_lo, 8'(idx_hi), byte_lo, 8'(byte_hi),
                          done_flag, done_mask);
      if (ap.offset == `NSW_OFF_IRQ_STAT) begin
        next_done_flag = 1'b0;
      end
    end
    if (dwr) begin
      case (ap.offset)
        `NSW_OFF_IDX_LO: next_idx_lo = wb;
        `NSW_OFF_IDX_HI: next_idx_hi = wb[`NSW_IDX_HI_W-1:0];
        `NSW_OFF_BYTE_LO: next_byte_lo = wb;
        `NSW_OFF_BYTE_HI: next_byte_hi = wb[`NSW_BYTE_HI_W-1:0];
        `NSW_OFF_IRQ_MASK: next_done_mask = wb[`NSW_B_DONE];
        `NSW_OFF_CONTROL: begin
          next_permit = wb[`NSW_B_PERMIT];
          next_abort_flag = wb[`NSW_B_ABORT];
          if (!strobe) begin
            next_code_sel = wb[`NSW_B_CODE];
          end
          if (wb[`NSW_B_FETCH] && !strobe && fstage == 2'h0) begin
            if (wb[`NSW_B_CODE]) begin
              next_fetch = 1'b1;
              next_fstage = `NSW_FETCH_LAT; // [R16]
            end else begin
              next_byte_lo = ee_mem[idx_lo]; // [R9]
            end
          end
          if (wb[`NSW_B_STROBE] && commit_ok) begin // [R3] [R13]
            next_op = '{is_code: wb[`NSW_B_CODE], index: index, data: byte_lo};
            if (wb[`NSW_B_CODE]) begin
              // Word goes to the block buffer; the last one programs
              next_blkbuf[idx_lo[2:0]] = {byte_hi, byte_lo}; // [R7]
              if (idx_lo[2:0] == `NSW_BLK_LAST) begin
                next_strobe = 1'b1; // [R15]
                next_wcnt = WW'(WR_CYC);
              end
            end else if (pwrt == '0) begin // [R2]
              next_strobe = 1'b1;
              next_wcnt = WW'(WR_CYC);
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Code fetch: array read in the second cycle, shown the next
    if (fstage != 2'h0) begin
      next_fstage = fstage - 2'h1;
      if (fstage == 2'h1) begin
        next_byte_lo = pf_mem[index][7:0]; // [R16]
        next_byte_hi = pf_mem[index][`NSW_WORD_W-1:8]; // [R16]
        next_fetch = 1'b0;
      end
    end
    // Completion: strobe drops, done flag set wins over read-clear
    if (finish) begin
      next_strobe = 1'b0; // [R14]
      next_done_flag = 1'b1; // [R14]
    end
    // Warm reset keeps data memory but drops any write in flight
    if (warm_reset) begin
      next_abort_flag = abort_flag | strobe; // [R18]
      next_permit = 1'b0;
      next_strobe = 1'b0;
      next_fetch = 1'b0;
      next_code_sel = 1'b0;
      next_fstage = 2'h0;
      next_wcnt = '0;
      next_idx_lo = 8'h00;
      next_idx_hi = '0;
      next_byte_lo = 8'h00;
      next_byte_hi = '0;
      next_ap = '0;
    end
  end

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  // Power-on clears the registers and erases the block buffer; the power-up interval starts here
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ap <= '0;
      op <= '0;
      code_sel <= 1'b0;
      abort_flag <= 1'b0;
      permit <= 1'b0; // [R1]
      strobe <= 1'b0;
      fetch <= 1'b0;
      idx_lo <= 8'h00;
      idx_hi <= '0;
      byte_lo <= 8'h00;
      byte_hi <= '0;
      done_flag <= 1'b0;
      done_mask <= 1'b0;
      pwrt <= PW'(PWRT_CYC); // [R2]
      wcnt <= '0;
      fstage <= 2'h0;
      rdata <= 32'h0000_0000;
      ext_q <= 8'h00;
      ext_den_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        blkbuf[i] <= `NSW_ERASED;
      end
    end else if (ce) begin
      ap <= next_ap;
      op <= next_op;
      code_sel <= next_code_sel;
      abort_flag <= next_abort_flag;
      permit <= next_permit;
      strobe <= next_strobe;
      fetch <= next_fetch;
      idx_lo <= next_idx_lo;
      idx_hi <= next_idx_hi;
      byte_lo <= next_byte_lo;
      byte_hi <= next_byte_hi;
      done_flag <= next_done_flag;
      done_mask <= next_done_mask;
      pwrt <= next_pwrt;
      wcnt <= next_wcnt;
      fstage <= next_fstage;
      rdata <= next_rdata;
      ext_q <= next_ext_q;
      ext_den_q <= next_ext_den_q;
      blkbuf <= next_blkbuf;
    end
  end

  // ee_mem and pf_mem have no reset, so no power-on clear of stored contents
  always_ff @(posedge clock) begin
    if (ce && finish && !warm_reset) begin
      if (op.is_code) begin
        for (int i = 0; i < 16; i++) begin
          // Sixteen-word erase, eight buffered words written back
          pf_mem[{op.index[12:4], 4'(i)}] <= (1'(i >> 3) == op.index[3])
                                             ? blkbuf[3'(i)] : `NSW_ERASED; // [R15]
        end
      end else begin
        ee_mem[op.index[7:0]] <= op.data; // [R9] [R14]
      end
    end
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  assign hreadyout = ~drd;
  assign hresp = 1'b0;
  assign hrdata = rdata;
  assign irq = done_flag & done_mask;
  assign busy = strobe;
  assign ext_rdata = ext_q;
  assign ext_denied = ext_den_q;
endmodule : nsw_top

// file: verif/nsw_top_props.sv
// Port checker for the self-write controller.
// Assumes it is bound to nsw_top; one clock domain.
`include "nsw_cfg.svh"
module nsw_props #(
  parameter int WR_CYC = 16
) (
  // Clock and resets
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic warm_reset,
  // Fuse and external port
  input wire logic data_protect_fuse,
  input wire logic ext_rd,
  input wire logic [7:0] ext_rdata,
  input wire logic ext_denied,
  // Bus and status
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy
);
  // ----
  // Helper logic
  // ----
  logic take;
  logic ctl_dph;
  logic [15:0] busy_cnt;
  assign take = hsel && hready && htrans[1] && ce;
  // Control data phase marker, busy length count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_dph <= 1'b0;
      busy_cnt <= 16'h0000;
    end else begin
      ctl_dph <= take && hwrite && (haddr[7:0] == `NSW_OFF_CONTROL);
      busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock);
  endclocking
  // Warm reset drops a bus phase, so it disables too
  default disable iff (!resetn || warm_reset);
  sequence s_rd_take;
    take && !hwrite;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd_take |=> s_rd_wait;
  endproperty
  property p_wr_nowait;
    take && hwrite |=> hreadyout;
  endproperty
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  property p_busy_len;
    $fell(busy) && !$past(warm_reset) |-> busy_cnt == 16'(WR_CYC);
  endproperty
  property p_busy_cause;
    $rose(busy) |-> $past(ctl_dph) && $past(hwdata[1]);
  endproperty
  property p_ext_deny;
    ext_rd && !data_protect_fuse |=> ext_denied && (ext_rdata == 8'h00);
  endproperty
  property p_ext_allow;
    ext_rd && data_protect_fuse |=> !ext_denied;
  endproperty
  property p_ext_idle;
    !ext_rd |=> !ext_denied && (ext_rdata == 8'h00);
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state not one cycle");
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write data phase stalled");
  a_resp_okay: assert property (p_resp_okay)
    else $error("response not OKAY");
  a_busy_len: assert property (p_busy_len)
    else $error("write time wrong");
  a_busy_cause: assert property (p_busy_cause)
    else $error("write started without control strobe");
  a_ext_deny: assert property (p_ext_deny)
    else $error("protected read not denied");
  a_ext_allow: assert property (p_ext_allow)
    else $error("unprotected read denied");
  a_ext_idle: assert property (p_ext_idle)
    else $error("external port active without request");
endmodule : nsw_props

bind nsw_top nsw_props #(.WR_CYC(WR_CYC)) nsw_props_inst (
  .clock(clock), .resetn(resetn), .ce(ce), .warm_reset(warm_reset),
  .data_protect_fuse(data_protect_fuse), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
  .ext_denied(ext_denied), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .busy(busy));

// file: verif/test_nvm_selfwrite_controller.sv
// Self-checking bench for the self-write controller.
// Assumes nsw_top with its checker bound; 50 MHz clock.
`include "nsw_cfg.svh"
module test_nvm_selfwrite_controller;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] off;
    logic [31:0] wd;
    logic [31:0] exp;
  } nsw_row_s;
  logic clock, resetn, ce, warm_reset, fuse, ext_rd, hwrite;
  logic [7:0] ext_addr, ext_rdata;
  logic ext_denied, hreadyout, hresp, irq, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int num_errors, checked, cyc, n;
  // Table rows: offset, written value, value read back
  nsw_row_s rows [7] = '{
    '{`NSW_OFF_IDX_LO, 32'hFFFFFFA5, 32'h000000A5},
    '{`NSW_OFF_IDX_HI, 32'h000000FF, 32'h0000001F},
    '{`NSW_OFF_BYTE_LO, 32'h0000005A, 32'h0000005A},
    '{`NSW_OFF_BYTE_HI, 32'h000000FF, 32'h0000003F},
    '{`NSW_OFF_IRQ_MASK, 32'h000000FF, 32'h00000001},
    '{`NSW_OFF_UNLOCK, 32'h00000055, 32'h00000000},
    '{8'h40, 32'h000000FF, 32'h00000000}};

  // Short counts keep the run brief
  nsw_top #(.PWRT_CYC(40), .WR_CYC(16)) nsw_top_inst (
    .clock(clock), .resetn(resetn), .ce(ce), .warm_reset(warm_reset),
    .data_protect_fuse(fuse), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .ext_rdata(ext_rdata), .ext_denied(ext_denied), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq(irq), .busy(busy));

  // ----
  // Tasks
  // ----
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h00000000;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h00000000);
    check(nm, rd, e);
  endtask : rchk

  // Permit, both keys back to back, then the strobe
  task automatic commit(input logic [7:0] c);
    xfer(1'b1, `NSW_OFF_CONTROL, {24'h000000, c | 8'h04});
    xfer(1'b1, `NSW_OFF_UNLOCK, {24'h000000, `NSW_KEY_FIRST});
    xfer(1'b1, `NSW_OFF_UNLOCK, {24'h000000, `NSW_KEY_SECOND});
    xfer(1'b1, `NSW_OFF_CONTROL, {24'h000000, c | 8'h06});
  endtask : commit

  // Counts busy cycles at falling edges, where busy is settled
  task automatic run_write();
    n = 0;
    @(negedge clock);
    while (busy === 1'b1) begin
      n++;
      @(negedge clock);
    end
    @(posedge clock);
  endtask : run_write

  // Code fetch takes two cycles to land in the byte registers; data fetch lands at once
  task automatic fetch(input logic [7:0] c);
    xfer(1'b1, `NSW_OFF_CONTROL, {24'h000000, c});
    repeat (2) @(posedge clock);
  endtask : fetch

  task automatic ext_chk(input logic [7:0] ed, input logic en);
    ext_addr <= 8'h21;
    ext_rd <= 1'b1;
    @(posedge clock);
    ext_rd <= 1'b0;
    @(negedge clock);
    check("ext_rdata", {24'h000000, ext_rdata}, {24'h000000, ed});
    check("ext_denied", {31'h0, ext_denied}, {31'h0, en});
    @(posedge clock);
  endtask : ext_chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // ----
  // Clock, timeout and main sequence
  // ----
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Whole run needs about 450 cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge clock);
      cyc++;
      if (cyc == 20000) begin
        num_errors++;
        summarize();
      end
    end
  end

  initial begin
    num_errors = 0;
    checked = 0;
    resetn = 1'b0;
    warm_reset = 1'b0;
    ce = 1'b1;
    fuse = 1'b1;
    ext_rd = 1'b0;
    ext_addr = 8'h00;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    // Commit inside the power-up interval is refused
    xfer(1'b1, `NSW_OFF_IDX_LO, 32'h00000021);
    commit(8'h00);
    run_write();
    check("early busy", 32'(n), 32'h0);
    $display("power-up interval test done");
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, rows[i].off, rows[i].wd);
      rchk(rows[i].off, rows[i].exp, "table");
    end
    $display("register table test done");
    repeat (40) @(posedge clock);
    // Data write, masked then unmasked done event
    xfer(1'b1, `NSW_OFF_IRQ_MASK, 32'h00000000);
    xfer(1'b1, `NSW_OFF_IDX_LO, 32'h00000021);
    xfer(1'b1, `NSW_OFF_BYTE_LO, 32'h0000003C);
    commit(8'h00);
    run_write();
    check("write time", 32'(n), 32'h10);
    rchk(`NSW_OFF_CONTROL, 32'h00000004, "control");
    check("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, `NSW_OFF_IRQ_MASK, 32'h00000001);
    rchk(`NSW_OFF_IDX_LO, 32'h00000021, "index");
    check("irq", {31'h0, irq}, 32'h1);
    rchk(`NSW_OFF_IRQ_STAT, 32'h00000001, "done");
    rchk(`NSW_OFF_IRQ_STAT, 32'h00000000, "done cleared");
    check("irq cleared", {31'h0, irq}, 32'h0);
    xfer(1'b1, `NSW_OFF_BYTE_LO, 32'h00000000);
    fetch(8'h05);
    rchk(`NSW_OFF_BYTE_LO, 32'h0000003C, "readback");
    $display("data write test done");
    // Broken orders: swapped keys, gap, late access, no permit
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `NSW_OFF_CONTROL, (i == 3) ? 32'h0 : 32'h4);
      xfer(1'b1, `NSW_OFF_UNLOCK, (i == 0) ? 32'hAA : 32'h55);
      if (i == 1) xfer(1'b0, `NSW_OFF_IDX_LO, 32'h0);
      xfer(1'b1, `NSW_OFF_UNLOCK, (i == 0) ? 32'h55 : 32'hAA);
      if (i == 2) xfer(1'b1, `NSW_OFF_IDX_LO, 32'h21);
      xfer(1'b1, `NSW_OFF_CONTROL, (i == 3) ? 32'h2 : 32'h6);
      run_write();
      check("refused", 32'(n), 32'h0);
    end
    $display("unlock order test done");
    // Flash block: eight buffered words, last one writes
    xfer(1'b1, `NSW_OFF_IDX_HI, 32'h00000001);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, `NSW_OFF_IDX_LO, 32'(8'h10 + k));
      xfer(1'b1, `NSW_OFF_BYTE_LO, 32'(k));
      xfer(1'b1, `NSW_OFF_BYTE_HI, 32'(8'h20 + k));
      commit(8'h80);
      run_write();
      check("block", 32'(n), (k == 7) ? 32'h10 : 32'h0);
    end
    xfer(1'b1, `NSW_OFF_IDX_LO, 32'h00000013);
    fetch(8'h81);
    rchk(`NSW_OFF_BYTE_LO, 32'h00000003, "word lo");
    rchk(`NSW_OFF_BYTE_HI, 32'h00000023, "word hi");
    xfer(1'b1, `NSW_OFF_IDX_LO, 32'h00000018);
    fetch(8'h81);
    rchk(`NSW_OFF_BYTE_LO, 32'h000000FF, "erased lo");
    rchk(`NSW_OFF_BYTE_HI, 32'h0000003F, "erased hi");
    $display("flash block test done");
    // External reads open, then protected
    xfer(1'b1, `NSW_OFF_IDX_HI, 32'h00000000);
    ext_chk(8'h3C, 1'b0);
    fuse <= 1'b0;
    ext_chk(8'h00, 1'b1);
    xfer(1'b1, `NSW_OFF_IDX_LO, 32'h00000021);
    fetch(8'h05);
    rchk(`NSW_OFF_BYTE_LO, 32'h0000003C, "cpu read");
    fuse <= 1'b1;
    $display("protection test done");
    // Warm reset in mid-write leaves the abort flag
    xfer(1'b1, `NSW_OFF_IDX_LO, 32'h00000022);
    commit(8'h00);
    // Clock enable low must freeze the write in flight
    ce <= 1'b0;
    repeat (20) @(posedge clock);
    check("frozen", {31'h0, busy}, 32'h1);
    ce <= 1'b1;
    repeat (4) @(posedge clock);
    warm_reset <= 1'b1;
    @(posedge clock);
    warm_reset <= 1'b0;
    @(posedge clock);
    xfer(1'b0, `NSW_OFF_CONTROL, 32'h0);
    check("abort", {31'h0, rd[3]}, 32'h1);
    check("busy", {31'h0, busy}, 32'h0);
    $display("warm reset test done");
    // Power-on reset clears permit and the index and data registers
    resetn <= 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    xfer(1'b0, `NSW_OFF_CONTROL, 32'h0);
    check("permit", {31'h0, rd[2]}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rchk(rows[i].off, 32'h0, "reset value");
    end
    $display("power-on reset test done");
    summarize();
  end
endmodule : test_nvm_selfwrite_controller
